/* File: srsf_pkg.sv */
package srsf_pkg;
  localparam logic [7:0] SRSF_STAT_ADDR   = 8'hEA;
  localparam logic [7:0] SRSF_RXBUF_ADDR  = 8'h9B;
  localparam logic [7:0] SRSF_STAT_RESET  = 8'h00;
  localparam int         SRSF_BIT_BUSY    = 7;
  localparam int         SRSF_BIT_MULTIMASTER_ERROR_FLAG   = 6;
  localparam int         SRSF_BIT_RXOF    = 5;
  localparam int         SRSF_BIT_RXIRQ   = 4;
  localparam int         SRSF_BIT_RXBF    = 3;
  localparam int         SRSF_BYTE_BITS   = 8;
  localparam logic [2:0] SRSF_LAST_BIT    = 3'h7;
  localparam logic [2:0] SRSF_LOW_MASK    = 3'h7;
endpackage : srsf_pkg

/* File: srsf_top.sv */
//Contract
// [RL1] Status register at 0xEA, upper five bits are flags, all zero after reset.
// [RL2] Bit 7 reads one while a transfer is in progress, zero when idle.
// [RL3] Select pulled low by another party during master transfer sets bit 6.
// [RL4] Software writes zero to bit 6 to clear it; one leaves it.
// [RL5] In transfer irq mode, unread byte overrun by next byte sets bit 5.
// [RL6] On overflow with overwrite enabled, the new byte replaces the unread one.
// [RL7] Reading the receive buffer clears the overflow flag.
// [RL8] New byte in the buffer sets bit 4; buffer read clears it. Code leaves it set when a byte waits in the tail.
// [RL9] With the serial irq enabled, the irq request follows the receive flag.
// [RL10] Mode cleared and buffer unread at byte end: halt and release select.
// [RL11] Bit 3 is set while the buffer holds data; a read clears it. Code leaves it set when a byte waits in the tail.
// [RL12] Software keeps the transfer irq mode bit at one; it resets to one.
`timescale 1ns/1ps
module srsf_top
  import srsf_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // Link pins, asynchronous to clk_i
  input  wire logic       sclk_i,
  input  wire logic       data_in_i,
  input  wire logic       sel_n_i,
  // Mode levels from the configuration registers, same clock
  input  wire logic       master_mode_i,
  input  wire logic       sel_in_enable_i,
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic       lsb_first_i,
  input  wire logic       transfer_irq_mode_i,
  input  wire logic       rx_overwrite_enable_i,
  input  wire logic       serial_irq_enable_i,
  input  wire logic       master_active_i,
  // Special-function register bus
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            irq_o,
  output logic            halt_o,
  output logic            sel_release_o
);
  import srsf_pkg::*;

  typedef struct packed {
    // Pin synchronisers; select is kept active high so reset means idle
    logic [1:0] sclk_s;
    logic [1:0] din_s;
    logic [1:0] sel_s;
    logic       sclk_q;
    // Receive shifter
    logic [7:0] shift;
    logic [2:0] cnt;
    logic       busy;
    logic [1:0] buf_vld;   // Two-entry buffer: [0] head, [1] tail
    logic [7:0] buf0;
    logic [7:0] buf1;
    // Status flags, halt and registered read data
    logic       multimaster_error_flag;
    logic       rxof;
    logic       rxirq;
    logic       halt;
    logic [7:0] rdata;
  } srsf_state_t;

  srsf_state_t st_ff;
  srsf_state_t nxt_st;

  logic       sample_edge;
  logic       rise;
  logic       fall;
  logic       sel_low;
  logic       byte_done;
  logic       rd_buf;
  logic [7:0] new_byte;
  logic       stat_hit;
  logic       rxbuf_hit;
  logic       link_busy;
  logic       shift_en;
  logic       pop;
  logic       multimaster_error_flag_clr;
  logic       multimaster_error_flag_set;

  // Edges come from the synchronised copy, so each pin edge shows about two cycles late
  assign rise        = st_ff.sclk_s[1] & ~st_ff.sclk_q;
  assign fall        = ~st_ff.sclk_s[1] & st_ff.sclk_q;
  // Sampling edge is the leading edge when phase is zero
  assign sample_edge = (cpol_i ^ cpha_i) ? fall : rise;
  assign sel_low     = st_ff.sel_s[1];
  assign stat_hit    = (sfr_addr_i == SRSF_STAT_ADDR);
  assign rxbuf_hit   = (sfr_addr_i == SRSF_RXBUF_ADDR);
  assign rd_buf      = sfr_rd_i && rxbuf_hit;
  assign link_busy   = master_mode_i ? master_active_i : sel_low;
  assign shift_en    = sample_edge && !st_ff.halt;
  assign pop         = rd_buf && st_ff.buf_vld[0];
  assign new_byte    = lsb_first_i ? {st_ff.din_s[1], st_ff.shift[7:1]}
                                   : {st_ff.shift[6:0], st_ff.din_s[1]};
  assign byte_done   = shift_en && (st_ff.cnt == SRSF_LAST_BIT) && link_busy;
  assign multimaster_error_flag_clr   = sfr_wr_i && stat_hit && !sfr_wdata_i[SRSF_BIT_MULTIMASTER_ERROR_FLAG];
  // Only a foreign select during our own master transfer counts as a collision
  assign multimaster_error_flag_set   = master_mode_i && master_active_i && sel_in_enable_i && sel_low;

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.sclk_s = {st_ff.sclk_s[0], sclk_i};
    nxt_st.din_s  = {st_ff.din_s[0], data_in_i};
    nxt_st.sel_s  = {st_ff.sel_s[0], ~sel_n_i};
    nxt_st.sclk_q = st_ff.sclk_s[1];
    nxt_st.busy   = link_busy;  // [RL2]

    // Counter restarts whenever the link goes idle, so a cut frame leaves no residue
    if (!link_busy) begin
      nxt_st.cnt = 3'h0;
    end else if (shift_en) begin
      nxt_st.shift = new_byte;
      nxt_st.cnt   = (st_ff.cnt + 3'h1) & SRSF_LOW_MASK;
    end

    // Read pops the head; the tail moves up
    if (pop) begin
      nxt_st.buf0    = st_ff.buf1;
      nxt_st.buf_vld = {1'b0, st_ff.buf_vld[1]};
      nxt_st.rxof    = 1'b0;  // [RL7]
      nxt_st.rxirq   = st_ff.buf_vld[1];  // [RL8]
      nxt_st.halt    = 1'b0;
    end

    // Byte end is judged after the pop, so a same-cycle read frees the head
    if (byte_done) begin
      if (!nxt_st.buf_vld[0]) begin
        nxt_st.buf0       = new_byte;
        nxt_st.buf_vld[0] = 1'b1;
        nxt_st.rxirq      = 1'b1;  // [RL8]
      end else if (!transfer_irq_mode_i) begin
        // Unread byte at byte end stalls the link until software reads
        nxt_st.halt = 1'b1;  // [RL10]
      end else begin
        nxt_st.rxof  = 1'b1;  // [RL5]
        nxt_st.rxirq = 1'b1;  // [RL8]
        if (rx_overwrite_enable_i) begin
          // With both slots full the tail is replaced; the head keeps the oldest byte
          if (nxt_st.buf_vld[1]) begin
            nxt_st.buf1 = new_byte;  // [RL6]
          end else begin
            nxt_st.buf0 = new_byte;  // [RL6]
          end
        end else if (!nxt_st.buf_vld[1]) begin
          // Tail slot absorbs one extra byte so a late read loses nothing
          nxt_st.buf1       = new_byte;
          nxt_st.buf_vld[1] = 1'b1;
        end
      end
    end

    if (multimaster_error_flag_clr) begin
      nxt_st.multimaster_error_flag = 1'b0;  // [RL4]
    end
    // Set wins over a same-cycle clear
    if (multimaster_error_flag_set) begin
      nxt_st.multimaster_error_flag = 1'b1;  // [RL3]
    end

    // Read data registers the view of the address presented this cycle
    nxt_st.rdata = 8'h00;
    if (stat_hit) begin
      nxt_st.rdata[SRSF_BIT_BUSY]  = st_ff.busy;
      nxt_st.rdata[SRSF_BIT_MULTIMASTER_ERROR_FLAG] = st_ff.multimaster_error_flag;
      nxt_st.rdata[SRSF_BIT_RXOF]  = st_ff.rxof;
      nxt_st.rdata[SRSF_BIT_RXIRQ] = st_ff.rxirq;
      nxt_st.rdata[SRSF_BIT_RXBF]  = st_ff.buf_vld[0];  // [RL11]
    end else if (rxbuf_hit) begin
      nxt_st.rdata = st_ff.buf0;
    end else begin
      // Unmapped addresses read as zero
      nxt_st.rdata = 8'h00;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= '0;  // [RL1]
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Halt holds until software reads the buffer; the select stays released meanwhile
  assign sfr_rdata_o   = st_ff.rdata;
  assign irq_o         = serial_irq_enable_i & st_ff.rxirq;  // [RL9]
  assign halt_o        = st_ff.halt;
  assign sel_release_o = st_ff.halt;  // [RL10]
endmodule : srsf_top

/* File: srsf_spi_model.sv */
`timescale 1ns/1ps
module srsf_spi_model (
  input  wire logic pol_i,
  input  wire logic pha_i,
  input  wire logic lsb_i,
  output logic      sclk_o,
  output logic      mosi_o,
  output logic      sel_n_o
);
  initial begin
    sclk_o  = 1'b0;
    mosi_o  = 1'b0;
    sel_n_o = 1'b1;
  end
  // Any mode and bit order; the clock settles to idle before select falls
  task automatic xfer(input logic [7:0] b);
    sclk_o = pol_i;
    #100 sel_n_o = 1'b0;
    #100;
    for (int i = 0; i < 8; i++) begin
      if (!pha_i) mosi_o = b[lsb_i ? i : 7 - i];
      #100 sclk_o = ~pol_i;
      if (pha_i) mosi_o = b[lsb_i ? i : 7 - i];
      #100 sclk_o = pol_i;
    end
    // Released line shows the inverse so a stale bit cannot pass
    #100 mosi_o = ~b[lsb_i ? 7 : 0];
    #100 sel_n_o = 1'b1;
    #300;
  endtask : xfer
  task automatic grab;
    sel_n_o = 1'b0;
    #200 sel_n_o = 1'b1;
    #100;
  endtask : grab
endmodule : srsf_spi_model

/* File: srsf_top_monitor.sv */
`timescale 1ns/1ps
module srsf_top_monitor
  import srsf_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       arst_n_i,
  input wire logic       master_mode_i,
  input wire logic       master_active_i,
  input wire logic       transfer_irq_mode_i,
  input wire logic       serial_irq_enable_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       irq_o,
  input wire logic       halt_o,
  input wire logic       sel_release_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wire stat = sfr_addr_i == SRSF_STAT_ADDR;
  chk_irq_enable: assert property (irq_o |-> serial_irq_enable_i) else $error("irq unmasked");
  chk_busy_shown: assert property (master_mode_i && master_active_i ##1 stat && master_active_i
    |=> sfr_rdata_o[7]) else $error("busy missing");
  chk_unmapped_zero: assert property (!stat && sfr_addr_i != SRSF_RXBUF_ADDR
    |=> sfr_rdata_o == 8'h00) else $error("unmapped nonzero");
  chk_read_clears: assert property (sfr_rd_i && sfr_addr_i == SRSF_RXBUF_ADDR ##[1:2] stat
    |=> !sfr_rdata_o[5]) else $error("overflow kept");
  chk_halt_mode: assert property ($rose(halt_o) |-> !$past(transfer_irq_mode_i))
    else $error("halt in irq mode");
  chk_halt_release: assert property (halt_o |-> sel_release_o) else $error("select held");
  chk_multimaster_error_flag_clear: assert property (sfr_wr_i && stat && !sfr_wdata_i[6] && !master_active_i
    ##1 stat |=> !sfr_rdata_o[6]) else $error("multimaster_error_flag kept");
  chk_flags_full: assert property ($past(stat) && |sfr_rdata_o[5:4] |-> sfr_rdata_o[3])
    else $error("full flag missing");
  cover property (halt_o);
  cover property (irq_o);
  cover property ($past(stat) && sfr_rdata_o[5]);
endmodule : srsf_top_monitor
bind srsf_top srsf_top_monitor u_srsf_top_monitor (.*);

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  import srsf_pkg::*;
  logic       clk_i = 0, arst_n_i = 0, sclk, mosi, sel_n, irq, halt, rel;
  logic       mm = 0, act = 0, selen = 0, tim = 1, ofw = 0, ien = 1, wr = 0, rd = 0;
  logic       cpol = 0, cpha = 0, lsbf = 0;
  logic [7:0] addr = 0, wd = 0, rdata;
  int         error_cnt = 0, cmp_count = 0;
  always #12.5 clk_i = ~clk_i;
  srsf_spi_model u_srsf_spi_model (.pol_i(cpol), .pha_i(cpha), .lsb_i(lsbf), .sclk_o(sclk),
    .mosi_o(mosi), .sel_n_o(sel_n));
  srsf_top u_srsf_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .data_in_i(mosi),
    .sel_n_i(sel_n), .master_mode_i(mm), .sel_in_enable_i(selen), .cpol_i(cpol),
    .cpha_i(cpha), .lsb_first_i(lsbf), .transfer_irq_mode_i(tim), .rx_overwrite_enable_i(ofw),
    .serial_irq_enable_i(ien), .master_active_i(act), .sfr_addr_i(addr), .sfr_wdata_i(wd),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .irq_o(irq), .halt_o(halt),
    .sel_release_o(rel));
  task automatic chk(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, exp);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rdc
  task automatic wrs(input logic [7:0] d);
    @(posedge clk_i);
    addr <= SRSF_STAT_ADDR;
    wd   <= d;
    wr   <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wrs
  task automatic t_rx;
    u_srsf_spi_model.xfer(8'hA5);
    chk({7'h0, irq}, 8'h01);
    @(posedge clk_i) ien <= 1'b0;
    @(posedge clk_i) #1 chk({7'h0, irq}, 8'h00);
    @(posedge clk_i) ien <= 1'b1;
    rdc(SRSF_STAT_ADDR, 8'h18);
    rdc(SRSF_RXBUF_ADDR, 8'hA5);
    rdc(SRSF_STAT_ADDR, 8'h00);
    rdc(8'h00, 8'h00);
  endtask : t_rx
  task automatic t_ovf;
    u_srsf_spi_model.xfer(8'h11);
    u_srsf_spi_model.xfer(8'h22);
    rdc(SRSF_STAT_ADDR, 8'h38);
    rdc(SRSF_RXBUF_ADDR, 8'h11);
    rdc(SRSF_STAT_ADDR, 8'h18);
    rdc(SRSF_RXBUF_ADDR, 8'h22);
    @(posedge clk_i) ofw <= 1'b1;
    u_srsf_spi_model.xfer(8'h33);
    u_srsf_spi_model.xfer(8'h44);
    rdc(SRSF_RXBUF_ADDR, 8'h44);
  endtask : t_ovf
  task automatic t_master;
    @(posedge clk_i) {mm, selen, act} <= 3'h7;
    rdc(SRSF_STAT_ADDR, 8'h80);
    u_srsf_spi_model.grab;
    rdc(SRSF_STAT_ADDR, 8'hC0);
    wrs(8'h40);
    rdc(SRSF_STAT_ADDR, 8'hC0);
    @(posedge clk_i) {mm, selen, act} <= 3'h0;
    wrs(8'h00);
    rdc(SRSF_STAT_ADDR, 8'h00);
  endtask : t_master
  task automatic t_halt;
    @(posedge clk_i) tim <= 1'b0;
    u_srsf_spi_model.xfer(8'h55);
    u_srsf_spi_model.xfer(8'h66);
    chk({6'h0, halt, rel}, 8'h03);
    rdc(SRSF_RXBUF_ADDR, 8'h55);
    @(posedge clk_i) tim <= 1'b1;
  endtask : t_halt
  task automatic t_modes;
    logic [7:0] b;
    for (int m = 1; m < 4; m++) begin
      b = 8'h16 + 8'(m);
      @(posedge clk_i) {cpol, cpha, lsbf} <= {m[1], m[0], m[0]};
      @(posedge clk_i);
      u_srsf_spi_model.xfer(b);
      rdc(SRSF_RXBUF_ADDR, b);
    end
  endtask : t_modes
  task automatic stop_test;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial begin
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rdc(SRSF_STAT_ADDR, SRSF_STAT_RESET);
    t_rx;
    t_ovf;
    t_master;
    t_halt;
    t_modes;
    stop_test;
  end
  initial begin
    #100000;
    error_cnt++;
    stop_test;
  end
endmodule : tb
